// ==== inc/timer16_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants for the 16-bit timer with compare reset
// Assumes: register indices are word indices; byte address = 4 * index
// Notes:   field positions except the compare mode field [3:0], mode codes and register reset values live here
//////////////////////////////////////////////////////////////////////////////
package timer16_pkg;

    // register indices
    localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00B;
    localparam logic [9:0] IDX_PERIPHERAL_FLAGS = 10'h00C;
    localparam logic [9:0] IDX_TIMER_COUNT_LOW = 10'h00E;
    localparam logic [9:0] IDX_TIMER_COUNT_HIGH = 10'h00F;
    localparam logic [9:0] IDX_TIMER_CONTROL = 10'h010;
    localparam logic [9:0] IDX_COMPARE_VALUE_LOW = 10'h015;
    localparam logic [9:0] IDX_COMPARE_VALUE_HIGH = 10'h016;
    localparam logic [9:0] IDX_COMPARE_UNIT_CONTROL = 10'h017;
    localparam logic [9:0] IDX_PERIPHERAL_ENABLES = 10'h08C;

    // decoded register selector
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_INTCTL = 4'h1,
        SEL_FLAGS = 4'h2,
        SEL_CNTLO = 4'h3,
        SEL_CNTHI = 4'h4,
        SEL_TCTL = 4'h5,
        SEL_CMPLO = 4'h6,
        SEL_CMPHI = 4'h7,
        SEL_CCTL = 4'h8,
        SEL_ENABLES = 4'h9
    } reg_sel_t;

    // timer control fields
    localparam int RUN_BIT = 0;
    localparam int CLOCK_SOURCE_BIT = 1;
    localparam int SYNC_SELECT_BIT = 2;
    localparam int OSC_ENABLE_BIT = 3;
    localparam int PRESCALE_LO = 4;
    localparam int PRESCALE_HI = 5;
    localparam logic [7:0] TIMER_CONTROL_MASK = 8'h3F;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;

    // compare unit control fields
    localparam logic [7:0] COMPARE_CONTROL_MASK = 8'h3F;
    localparam logic [7:0] COMPARE_CONTROL_RESET = 8'h00;
    localparam logic [3:0] MODE_CMP_SET_PIN = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR_PIN = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT_INT = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIGGER = 4'hB;
    localparam logic [1:0] MODE_CMP_GROUP = 2'h2;

    // flag / enable fields
    localparam int OVERFLOW_FLAG_BIT = 0;
    localparam int COMPARE_FLAG_BIT = 2;
    localparam logic [7:0] FLAG_MASK = 8'h05;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [7:0] INTCTL_RESET = 8'h00;

    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

endpackage

// ==== hw/timer16_with_compare_reset.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: 16-bit timer with prescaler, crystal oscillator and compare unit
// Assumes: APB slave, one wait state; all inputs synchronous to clk
// Notes:   rst is power-on / brown-out; otherReset is any other reset
//////////////////////////////////////////////////////////////////////////////
module timer16_with_compare_reset #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic otherReset,
    input wire logic crystalInPin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic crystalOutPin,
    output logic compareOutPin,
    output logic specialTrigger,
    output logic irq
);

    //////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic timer16_pkg::reg_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
        logic [9:0] idx;
        idx = 10'(addr[ADDR_WIDTH-1:2]);
        if (addr[1:0] != 2'h0)
        begin
            return timer16_pkg::SEL_NONE;
        end
        unique case (idx)
            timer16_pkg::IDX_INTERRUPT_CONTROL: return timer16_pkg::SEL_INTCTL;
            timer16_pkg::IDX_PERIPHERAL_FLAGS: return timer16_pkg::SEL_FLAGS;
            timer16_pkg::IDX_TIMER_COUNT_LOW: return timer16_pkg::SEL_CNTLO;
            timer16_pkg::IDX_TIMER_COUNT_HIGH: return timer16_pkg::SEL_CNTHI;
            timer16_pkg::IDX_TIMER_CONTROL: return timer16_pkg::SEL_TCTL;
            timer16_pkg::IDX_COMPARE_VALUE_LOW: return timer16_pkg::SEL_CMPLO;
            timer16_pkg::IDX_COMPARE_VALUE_HIGH: return timer16_pkg::SEL_CMPHI;
            timer16_pkg::IDX_COMPARE_UNIT_CONTROL: return timer16_pkg::SEL_CCTL;
            timer16_pkg::IDX_PERIPHERAL_ENABLES: return timer16_pkg::SEL_ENABLES;
            default: return timer16_pkg::SEL_NONE;
        endcase
    endfunction

    logic [7:0] intCtl_ff;
    logic [7:0] flags_ff;
    logic [7:0] enables_ff;
    logic [7:0] timerCtl_ff;
    logic [7:0] cmpCtl_ff;
    logic [15:0] count_ff;
    logic [15:0] compare_ff;
    logic [2:0] prescale_ff;
    logic crystalPrev_ff;
    logic matchPrev_ff;

    timer16_pkg::reg_sel_t sel;
    logic wrEn;
    logic [7:0] wrByte;
    logic cntLoWr;
    logic cntHiWr;
    logic countWr;

    //////////////////////////////////////////////////////////////////////////
    // register write strobes
    assign sel = decode(paddr);
    // write lands at the edge where pready is seen high
    assign wrEn = psel && penable && pready && pwrite && pstrb[0] && (sel != timer16_pkg::SEL_NONE);
    assign wrByte = pwdata[7:0];
    assign cntLoWr = wrEn && (sel == timer16_pkg::SEL_CNTLO);
    assign cntHiWr = wrEn && (sel == timer16_pkg::SEL_CNTHI);
    // either byte counts as a count write: wins over trigger and increment
    assign countWr = cntLoWr || cntHiWr;

    //////////////////////////////////////////////////////////////////////////
    // APB response
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= (sel == timer16_pkg::SEL_NONE);
            // reads only: read data holds across writes
            if (!pwrite)
            begin
                unique case (sel)
                    timer16_pkg::SEL_INTCTL: prdata <= {24'h000000, intCtl_ff};
                    timer16_pkg::SEL_FLAGS: prdata <= {24'h000000, flags_ff & timer16_pkg::FLAG_MASK};
                    timer16_pkg::SEL_CNTLO: prdata <= {24'h000000, count_ff[7:0]};
                    timer16_pkg::SEL_CNTHI: prdata <= {24'h000000, count_ff[15:8]};
                    timer16_pkg::SEL_TCTL: prdata <= {24'h000000, timerCtl_ff & timer16_pkg::TIMER_CONTROL_MASK};
                    timer16_pkg::SEL_CMPLO: prdata <= {24'h000000, compare_ff[7:0]};
                    timer16_pkg::SEL_CMPHI: prdata <= {24'h000000, compare_ff[15:8]};
                    timer16_pkg::SEL_CCTL: prdata <= {24'h000000, cmpCtl_ff & timer16_pkg::COMPARE_CONTROL_MASK};
                    timer16_pkg::SEL_ENABLES: prdata <= {24'h000000, enables_ff & timer16_pkg::FLAG_MASK};
                    timer16_pkg::SEL_NONE: prdata <= 32'h0000_0000;
                endcase
            end
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // timer control: only power-on / brown-out clears it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timerCtl_ff <= timer16_pkg::TIMER_CONTROL_RESET;
        end
        else if (wrEn && sel == timer16_pkg::SEL_TCTL)
        begin
            timerCtl_ff <= wrByte & timer16_pkg::TIMER_CONTROL_MASK;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // controls that every reset clears
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmpCtl_ff <= timer16_pkg::COMPARE_CONTROL_RESET;
            enables_ff <= timer16_pkg::ENABLES_RESET;
            intCtl_ff <= timer16_pkg::INTCTL_RESET;
        end
        else if (otherReset)
        begin
            cmpCtl_ff <= timer16_pkg::COMPARE_CONTROL_RESET;
            enables_ff <= timer16_pkg::ENABLES_RESET;
            intCtl_ff <= timer16_pkg::INTCTL_RESET;
        end
        else if (wrEn)
        begin
            if (sel == timer16_pkg::SEL_CCTL)
            begin
                cmpCtl_ff <= wrByte & timer16_pkg::COMPARE_CONTROL_MASK;
            end
            if (sel == timer16_pkg::SEL_ENABLES)
            begin
                enables_ff <= wrByte & timer16_pkg::FLAG_MASK;
            end
            if (sel == timer16_pkg::SEL_INTCTL)
            begin
                intCtl_ff <= wrByte;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // compare value: data register, no reset
    always_ff @(posedge clk)
    begin
        if (wrEn && sel == timer16_pkg::SEL_CMPLO)
        begin
            compare_ff[7:0] <= wrByte;
        end
        if (wrEn && sel == timer16_pkg::SEL_CMPHI)
        begin
            compare_ff[15:8] <= wrByte;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // oscillator amplifier and clock source
    logic runOn;
    logic extSel;
    logic extEdge;
    logic srcTick;
    logic [2:0] prescaleLimit;
    logic preTick;

    assign runOn = timerCtl_ff[timer16_pkg::RUN_BIT];
    assign extSel = timerCtl_ff[timer16_pkg::CLOCK_SOURCE_BIT];
    // async and sync counter modes both count here on the sampled edge
    assign extEdge = crystalInPin && !crystalPrev_ff;
    assign srcTick = runOn && (extSel ? extEdge : 1'b1);
    // divide by 1, 2, 4 or 8 from the two prescale bits
    assign prescaleLimit = 3'((4'h1 << timerCtl_ff[timer16_pkg::PRESCALE_HI:timer16_pkg::PRESCALE_LO]) - 4'h1);
    assign preTick = srcTick && (prescale_ff == prescaleLimit);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            crystalPrev_ff <= 1'b0;
            crystalOutPin <= 1'b0;
        end
        else
        begin
            crystalPrev_ff <= crystalInPin;
            // no sleep input: amplifier keeps running whenever enabled
            crystalOutPin <= timerCtl_ff[timer16_pkg::OSC_ENABLE_BIT] && !crystalInPin;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prescale_ff <= 3'h0;
        end
        else if (countWr)
        begin
            prescale_ff <= 3'h0;
        end
        else if (preTick)
        begin
            prescale_ff <= 3'h0;
        end
        else if (srcTick)
        begin
            prescale_ff <= prescale_ff + 3'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // compare unit
    logic [3:0] cmpMode;
    logic cmpActive;
    logic matchNow;
    logic matchEvent;
    logic trigger;
    logic overflowEvent;

    assign cmpMode = cmpCtl_ff[3:0];
    assign cmpActive = (cmpMode[3:2] == timer16_pkg::MODE_CMP_GROUP);
    // compare results only meaningful in timer or synchronized counter mode
    assign matchNow = cmpActive && (count_ff == compare_ff);
    // equality held over several prescaled cycles flags only once
    assign matchEvent = matchNow && !matchPrev_ff;
    assign trigger = matchEvent && (cmpMode == timer16_pkg::MODE_CMP_TRIGGER);
    // no wrap, so no overflow, when a count write or trigger clear wins
    assign overflowEvent = preTick && (count_ff == timer16_pkg::COUNT_ALL_ONES) && !trigger && !countWr;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            matchPrev_ff <= 1'b0;
            specialTrigger <= 1'b0;
            compareOutPin <= 1'b0;
        end
        else if (otherReset)
        begin
            matchPrev_ff <= 1'b0;
            specialTrigger <= 1'b0;
            compareOutPin <= 1'b0;
        end
        else
        begin
            matchPrev_ff <= matchNow;
            specialTrigger <= trigger;
            if (matchEvent && cmpMode == timer16_pkg::MODE_CMP_SET_PIN)
            begin
                compareOutPin <= 1'b1;
            end
            else if (matchEvent && cmpMode == timer16_pkg::MODE_CMP_CLR_PIN)
            begin
                compareOutPin <= 1'b0;
            end
            // soft-interrupt and trigger modes hold the pin
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // 16-bit count: survives every reset
    always_ff @(posedge clk)
    begin
        if (countWr)
        begin
            if (cntLoWr)
            begin
                count_ff[7:0] <= wrByte;
            end
            if (cntHiWr)
            begin
                count_ff[15:8] <= wrByte;
            end
        end
        else if (trigger)
        begin
            count_ff <= timer16_pkg::COUNT_ZERO;
        end
        else if (preTick)
        begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // sticky flags, write one to clear, set wins
    logic [7:0] setBits;
    logic [7:0] clrBits;
    logic [7:0] nxt_flags;

    always_comb
    begin
        setBits = 8'h00;
        setBits[timer16_pkg::OVERFLOW_FLAG_BIT] = overflowEvent;
        setBits[timer16_pkg::COMPARE_FLAG_BIT] = matchEvent;
        clrBits = (wrEn && sel == timer16_pkg::SEL_FLAGS) ? wrByte : 8'h00;
        nxt_flags = ((flags_ff & ~clrBits) | setBits) & timer16_pkg::FLAG_MASK;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_ff <= timer16_pkg::FLAGS_RESET;
        end
        else if (otherReset)
        begin
            // an event in the reset cycle still sets its flag
            flags_ff <= timer16_pkg::FLAGS_RESET | setBits;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt output
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else if (otherReset)
        begin
            // enables clear here, so nothing stays unmasked
            irq <= 1'b0;
        end
        else
        begin
            // raised only for enabled flags
            irq <= |(nxt_flags & enables_ff);
        end
    end

endmodule // timer16_with_compare_reset

// ==== tb/timer16_monitor.sv ====
// Purpose: port checker for the 16-bit timer
// Assumes: APB slave with exactly one wait state
// Notes:   bound to the design top at the foot of this file
module timer16_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic otherReset,
    input wire logic crystalInPin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic crystalOutPin,
    input wire logic specialTrigger,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_ready_wait: assert property (psel && !penable ##1 penable |-> !pready ##1 pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved outside a read");
    a_trig_pulse: assert property (specialTrigger |=> !specialTrigger)
        else $error("trigger longer than one cycle");
    a_osc_drive: assert property (crystalOutPin |-> !$past(crystalInPin))
        else $error("crystal drive not inverse of input");
    a_irq_clear: assert property (otherReset |-> ##2 !irq)
        else $error("interrupt survived soft reset");
endmodule // timer16_monitor

bind timer16_with_compare_reset timer16_monitor i_timer16_monitor (
    .clk(clk),
    .rst(rst),
    .otherReset(otherReset),
    .crystalInPin(crystalInPin),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .crystalOutPin(crystalOutPin),
    .specialTrigger(specialTrigger),
    .irq(irq)
);

// ==== tb/crystal_partner.sv ====
// Purpose: crystal model on the oscillator pins
// Assumes: crystal answers the amplifier after a few core cycles
// Notes:   with the amplifier off the input stands still low
module crystal_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic crystalOutPin,
    output logic crystalInPin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            crystalInPin <= 1'b0;
        end
        else if (cnt >= (slow ? 6 : 1))
        begin
            cnt <= 0;
            crystalInPin <= crystalOutPin;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
endmodule // crystal_partner

// ==== tb/test_timer16_with_compare_reset.sv ====
// Purpose: self-checking bench for the 16-bit timer
// Assumes: byte address is four times the register index
// Notes:   periods and counts drawn from a fixed seed
module test_timer16_with_compare_reset;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] TCTL = timer16_pkg::IDX_TIMER_CONTROL;
    localparam logic [9:0] FLG = timer16_pkg::IDX_PERIPHERAL_FLAGS;
    localparam logic [9:0] ENA = timer16_pkg::IDX_PERIPHERAL_ENABLES;
    localparam logic [9:0] CCTL = timer16_pkg::IDX_COMPARE_UNIT_CONTROL;
    localparam logic [9:0] CLO = timer16_pkg::IDX_TIMER_COUNT_LOW;
    localparam logic [9:0] CHI = timer16_pkg::IDX_TIMER_COUNT_HIGH;
    localparam logic [9:0] VLO = timer16_pkg::IDX_COMPARE_VALUE_LOW;
    logic clk, rst, otherReset, crystalInPin, psel, penable, pwrite, pready, pslverr, slow;
    logic crystalOutPin, compareOutPin, specialTrigger, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] rd, c0;
    logic [9:0] rIdx [5] = '{TCTL, FLG, CCTL, ENA, timer16_pkg::IDX_INTERRUPT_CONTROL};
    logic [3:0] md [3] = '{timer16_pkg::MODE_CMP_SET_PIN, timer16_pkg::MODE_CMP_CLR_PIN,
                           timer16_pkg::MODE_CMP_SOFT_INT};
    logic [7:0] pinExp [3] = '{8'h01, 8'h00, 8'h00};
    int nMismatch, cmpCount, seed, n, k, t, t0;

    timer16_with_compare_reset #(.ADDR_WIDTH(12)) i_timer16_with_compare_reset (.clk(clk), .rst(rst),
        .otherReset(otherReset), .crystalInPin(crystalInPin), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystalOutPin(crystalOutPin),
        .compareOutPin(compareOutPin), .specialTrigger(specialTrigger), .irq(irq));
    crystal_partner i_crystal_partner (.clk(clk), .rst(rst), .slow(slow),
        .crystalOutPin(crystalOutPin), .crystalInPin(crystalInPin));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task miss(input string m);
        nMismatch++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp)
            miss($sformatf("byte %h, expected %h", got, exp));
    endtask

    task chkn(input int got, input int exp);
        cmpCount++;
        if (got != exp)
            miss($sformatf("count %0d, expected %0d", got, exp));
    endtask

    task bus(input logic w, input logic [9:0] i, input logic [7:0] d);
        int c;
        c = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'($random(seed)), d};
        @(posedge clk);
        penable <= 1'b1;
        // pready is read before this edge's updates land
        do
        begin
            @(posedge clk);
            c++;
        end
        while (pready !== 1'b1 && c < 20);
        if (c >= 20)
            miss("no ready");
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task waitev(input bit trig, output int w);
        w = 0;
        do
        begin
            @(negedge clk);
            w++;
        end
        while ((trig ? specialTrigger : irq) !== 1'b1 && w < 3000);
        if (w >= 3000)
            miss("event never came");
    endtask

    task pulse_reset(input bit hard);
        @(posedge clk);
        if (hard)
            rst <= 1'b1;
        else
            otherReset <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        otherReset <= 1'b0;
    endtask

    task finish_test;
        $display("mismatches %0d, comparisons %0d", nMismatch, cmpCount);
        if (nMismatch == 0 && cmpCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #200000;
        nMismatch++;
        finish_test();
    end

    initial
    begin
        seed = 32'h6441;
        {rst, otherReset, psel, penable, pwrite, slow, err} = 7'h40;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rIdx[j])
        begin
            bus(1'b0, rIdx[j], 8'h00);
            chk(rd, 8'h00);
        end
        bus(1'b0, 10'h3FF, 8'h00);
        chk({rd[6:0], err}, 8'h01);
        $display("done: reset values");
        bus(1'b1, TCTL, 8'h30);
        bus(1'b1, CLO, 8'h34);
        bus(1'b1, CHI, 8'h12);
        pulse_reset(1'b0);
        bus(1'b0, TCTL, 8'h00);
        chk(rd, 8'h30);
        pulse_reset(1'b1);
        bus(1'b0, TCTL, 8'h00);
        chk(rd, 8'h00);
        bus(1'b0, CLO, 8'h00);
        chk(rd, 8'h34);
        bus(1'b0, CHI, 8'h00);
        chk(rd, 8'h12);
        $display("done: resets");
        k = 40 + int'($random(seed) & 31);
        bus(1'b1, ENA, 8'h01);
        for (int p = 0; p < 4; p++)
        begin
            bus(1'b1, FLG, 8'h05);
            bus(1'b1, TCTL, 8'(p << 4 | 1));
            bus(1'b1, CHI, 8'hFF);
            bus(1'b1, CLO, 8'(255 - k));
            waitev(1'b0, t);
            if (p == 0)
                t0 = t;
            else
                chkn(t - t0, (k + 1) * ((1 << p) - 1));
        end
        $display("done: prescaler and overflow");
        n = 2 + int'($random(seed) & 15);
        bus(1'b1, ENA, 8'h04);
        bus(1'b1, TCTL, 8'h01);
        bus(1'b1, VLO + 10'h001, 8'h00);
        bus(1'b1, VLO, 8'(n));
        bus(1'b1, CCTL, {4'h0, timer16_pkg::MODE_CMP_TRIGGER});
        bus(1'b1, CHI, 8'h00);
        bus(1'b1, CLO, 8'h00);
        bus(1'b1, FLG, 8'h05);
        waitev(1'b1, t);
        waitev(1'b1, t);
        chkn(t, n + 1);
        bus(1'b0, FLG, 8'h00);
        chk(rd, 8'h04);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, ENA, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        $display("done: period trigger");
        bus(1'b1, ENA, 8'h04);
        foreach (md[j])
        begin
            bus(1'b1, CCTL, {4'h0, md[j]});
            bus(1'b1, FLG, 8'h05);
            bus(1'b1, CHI, 8'h00);
            bus(1'b1, CLO, 8'h00);
            waitev(1'b0, t);
            chk({7'h0, compareOutPin}, pinExp[j]);
        end
        $display("done: compare modes");
        bus(1'b1, CCTL, 8'h00);
        bus(1'b1, TCTL, 8'h03);
        bus(1'b1, CLO, 8'h00);
        repeat (40) @(posedge clk);
        bus(1'b0, CLO, 8'h00);
        chk(rd, 8'h00);
        bus(1'b1, TCTL, 8'h0B);
        repeat (20) @(posedge clk);
        for (int s = 0; s < 2; s++)
        begin
            slow <= 1'(s);
            bus(1'b1, CLO, 8'h00);
            repeat (60) @(posedge clk);
            bus(1'b0, CLO, 8'h00);
            if (s == 0)
                c0 = rd;
        end
        chkn(int'(rd > 0 && rd < c0 && c0 <= 8'd32), 1);
        $display("done: crystal clock");
        finish_test();
    end
endmodule // test_timer16_with_compare_reset
